/* alarm_indicator.sv */
// Front panel LED and alarm line logic of a rack power supply.
//
// Summary of operation
// R1: Thermal warning lights amber, pulls warning line
// R2: Thermal shutdown: output off, amber, red, lines low
// R3: Fuse, boost, overvoltage: output off, red, lines
// R4: Single fan faults; two fans force shutdown
// R5: Input out of limits blinks input LED
// R6: Overload blinks output LED, pulses power-good 1 ms
// R7: Internal non-fatal fault: red LED, fault low
// R8: Serial mode service request blinks amber LED
// R9: Multidrop communication loss blinks red LED only
// R10: Standby: output off, power-good low, present low
// R11: Power-good warning low before output loss
// R12: Fault line high normally, low on fault
// R13: Outside party grounds on/off to enable output; multidrop mode ignores the pin
// R14: Protocol select input picks management mode
// R15: Interlock gates the main output
// R16: Slot select level gives low address bits
// R17: Most severe condition wins; common blink period
// R18: Active low alert on any new flag
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns
`include "supply_cfg.svh"
module alarm_indicator
   import supply_pkg::*;
#(
   parameter int PULSE_CYCLES = `PG_PULSE_CYCLES
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // Register port
   input wire logic [7:0] i_address,
   input wire logic [31:0] i_write_data,
   input wire logic i_write_strobe,
   input wire logic i_read_strobe,
   output logic [31:0] o_read_data,
   // Condition flags from the power train
   input wire logic i_therm_warn,
   input wire logic i_therm_shutdown,
   input wire logic i_fan_a_fault,
   input wire logic i_fan_b_fault,
   input wire logic i_input_absent,
   input wire logic i_input_out_of_limits,
   input wire logic i_fuse_blown,
   input wire logic i_boost_fail,
   input wire logic i_ov_latched,
   input wire logic i_overload,
   input wire logic i_internal_fault,
   input wire logic i_remote_standby,
   input wire logic i_service_request,
   input wire logic i_comm_lost,
   // Control pins
   input wire logic i_output_on_request_n,
   input wire logic i_interlock_mated,
   input wire logic i_protocol_open,
   input wire logic [3:0] i_slot_address_level,
   input wire logic [3:0] i_shelf_address_level,
   // Open drain alarm lines
   input wire logic i_fault_n_in,
   output logic o_fault_n_out,
   output logic o_fault_n_oe_n,
   input wire logic i_overtemp_warn_n_in,
   output logic o_overtemp_warn_n_out,
   output logic o_overtemp_warn_n_oe_n,
   input wire logic i_output_loss_warn_n_in,
   output logic o_output_loss_warn_n_out,
   output logic o_output_loss_warn_n_oe_n,
   input wire logic i_alert_n_in,
   output logic o_alert_n_out,
   output logic o_alert_n_oe_n,
   // Front panel LEDs, high is lit
   output logic o_led_input,
   output logic o_led_output,
   output logic o_led_service,
   output logic o_led_fault,
   // Status outputs
   output logic o_module_inserted_out,
   output logic o_main_output_enable,
   output logic [3:0] o_slot_address,
   output logic o_mode_serial
);

   generate
      if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << `PG_PULSE_WIDTH))
      begin : g_bad_pulse
         $error("PULSE_CYCLES out of range for the pulse counter");
      end
   endgenerate

   // A steady request beats a blinking one.
   function automatic logic led_pick(input logic steady, input logic blinking, input logic phase);
      led_pick = steady | (blinking & phase);
   endfunction

   // ======================================================================
   // Registers and timebases
   logic [`BLINK_WIDTH-1:0] blink_half_r;
   logic [`FLAG_COUNT-1:0] flags_prev_r;
   logic [`FLAG_COUNT-1:0] events_r;
   logic [`FLAG_COUNT-1:0] events_nxt;
   logic pulse_phase_r;
   logic blink_phase_r;
   mgmt_mode_t mode_r;
   logic ms_tick;
   logic blink_tick;

   tick_divider #(.WIDTH(`PG_PULSE_WIDTH)) u_ms_divider
   (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_enable(1'b1),
      .i_limit(PULSE_CYCLES[`PG_PULSE_WIDTH-1:0]),
      .o_tick(ms_tick)
   );

   // The blink period counts milliseconds so one short register covers seconds.
   tick_divider #(.WIDTH(`BLINK_WIDTH)) u_blink_divider
   (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_enable(ms_tick),
      .i_limit(blink_half_r),
      .o_tick(blink_tick)
   );

   // ======================================================================
   // Condition decode
   wire [`FLAG_COUNT-1:0] flags = {i_comm_lost, i_service_request, i_remote_standby, i_internal_fault,
      i_overload, i_ov_latched, i_boost_fail, i_fuse_blown, i_input_out_of_limits, i_input_absent,
      i_fan_b_fault, i_fan_a_fault, i_therm_shutdown, i_therm_warn};
   wire serial_mode = (mode_r == MODE_SERIAL);
   wire fan_any = i_fan_a_fault | i_fan_b_fault; // R4
   wire fan_double = i_fan_a_fault & i_fan_b_fault; // R4
   wire shutdown = i_therm_shutdown | i_fuse_blown | i_boost_fail | i_ov_latched | fan_double; // R2 R3 R4 R17
   wire fault_cond = shutdown | fan_any | i_internal_fault; // R12 R7
   wire otw_cond = i_therm_warn | i_therm_shutdown; // R1 R2
   wire input_bad = i_input_absent | i_input_out_of_limits;
   wire on_ok = !serial_mode || !i_output_on_request_n; // R13
   wire output_en = on_ok & i_interlock_mated & !shutdown & !i_remote_standby & !input_bad; // R15 R10
   wire pg_low = shutdown | fan_any | !output_en; // R11 R5 R10
   wire pg_drive_low = pg_low | (i_overload & pulse_phase_r); // R6 R17
   wire led_in_nxt = led_pick(!input_bad, !i_input_absent & i_input_out_of_limits, blink_phase_r); // R5
   wire led_out_nxt = led_pick(output_en & !i_overload, output_en & i_overload, blink_phase_r); // R6
   wire led_svc_nxt = led_pick(otw_cond, serial_mode & i_service_request, blink_phase_r); // R1 R8
   wire led_flt_nxt = led_pick(fault_cond, !serial_mode & i_comm_lost, blink_phase_r); // R9
   wire [`FLAG_COUNT-1:0] rise = flags & ~flags_prev_r;

   // ======================================================================
   // Register port decode
   wire wr_ctrl = i_write_strobe && (i_address == `REG_CTRL);
   wire wr_events = i_write_strobe && (i_address == `REG_EVENTS);
   wire [`FLAG_COUNT-1:0] ev_clear = wr_events ? i_write_data[`FLAG_COUNT-1:0] : '0;
   wire [16:0] lines_word = {i_shelf_address_level, o_slot_address, o_mode_serial, o_led_fault,
      o_led_service, o_led_output, o_led_input, i_alert_n_in, i_output_loss_warn_n_in,
      i_overtemp_warn_n_in, i_fault_n_in};
   wire [31:0] read_mux = (i_address == `REG_CTRL) ? {16'h0000, blink_half_r} :
      (i_address == `REG_FLAGS) ? {18'h00000, flags} :
      (i_address == `REG_EVENTS) ? {18'h00000, events_r} :
      (i_address == `REG_LINES) ? {15'h0000, lines_word} : 32'h00000000;

   // A new event beats a clear written in the same cycle.
   assign events_nxt = (events_r & ~ev_clear) | rise; // R18

   // ======================================================================
   // State
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         blink_half_r <= `CTRL_BLINK_RESET;
         flags_prev_r <= '0;
         events_r <= '0;
         pulse_phase_r <= 1'b0;
         blink_phase_r <= 1'b0;
         mode_r <= MODE_SERIAL;
         o_read_data <= 32'h00000000;
      end
      else
      begin
         if (wr_ctrl)
            blink_half_r <= i_write_data[`BLINK_WIDTH-1:0]; // R17
         flags_prev_r <= flags;
         events_r <= events_nxt;
         if (ms_tick)
            pulse_phase_r <= !pulse_phase_r; // R6
         if (blink_tick)
            blink_phase_r <= !blink_phase_r; // R17
         mode_r <= i_protocol_open ? MODE_SERIAL : MODE_MULTIDROP; // R14
         o_read_data <= i_read_strobe ? read_mux : 32'h00000000;
      end
   end

   // ======================================================================
   // Pin outputs
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         o_fault_n_oe_n <= 1'b1;
         o_overtemp_warn_n_oe_n <= 1'b1;
         o_output_loss_warn_n_oe_n <= 1'b0;
         o_alert_n_oe_n <= 1'b1;
         o_led_input <= 1'b0;
         o_led_output <= 1'b0;
         o_led_service <= 1'b0;
         o_led_fault <= 1'b0;
         o_main_output_enable <= 1'b0;
         o_slot_address <= 4'h0;
         o_mode_serial <= `MODE_RESET;
      end
      else
      begin
         o_fault_n_oe_n <= !fault_cond; // R12
         o_overtemp_warn_n_oe_n <= !otw_cond; // R1
         o_output_loss_warn_n_oe_n <= !pg_drive_low; // R11
         o_alert_n_oe_n <= !(|events_r); // R18
         o_led_input <= led_in_nxt;
         o_led_output <= led_out_nxt;
         o_led_service <= led_svc_nxt;
         o_led_fault <= led_flt_nxt;
         o_main_output_enable <= output_en; // R15
         o_slot_address <= i_slot_address_level; // R16
         o_mode_serial <= serial_mode;
      end
   end

   // Open drain lines only ever pull low.
   assign o_fault_n_out = 1'b0;
   assign o_overtemp_warn_n_out = 1'b0;
   assign o_output_loss_warn_n_out = 1'b0;
   assign o_alert_n_out = 1'b0;
   assign o_module_inserted_out = 1'b0; // R10

   // ======================================================================
   // Checks
   wire ovl_only = i_overload & !pg_low;
   // Service and link blinks may share the panel, so they are kept out of the input limit check.
   wire oor_only = i_input_out_of_limits & !i_input_absent & !fault_cond & !otw_cond & !i_service_request & !i_comm_lost;
   wire sby_only = i_remote_standby & !fault_cond & !input_bad;

   sequence s_ovl_tick;
      (ms_tick && ovl_only) ##1 ovl_only;
   endsequence

   property p_fault_line;
      @(posedge i_clock) disable iff (!i_resetn)
         fault_cond |=> (o_fault_n_oe_n == 1'b0);
   endproperty
   a_fault_line: assert property (p_fault_line) else $error("fault line not pulled on fault"); // R12

   property p_otw_line;
      @(posedge i_clock) disable iff (!i_resetn)
         (i_therm_warn && !fault_cond) |=> (!o_overtemp_warn_n_oe_n && o_fault_n_oe_n && o_led_service);
   endproperty
   a_otw_line: assert property (p_otw_line) else $error("thermal warning indication wrong"); // R1

   property p_therm_shut;
      @(posedge i_clock) disable iff (!i_resetn)
         i_therm_shutdown |=> (!o_led_output && o_led_service && o_led_fault && !o_output_loss_warn_n_oe_n);
   endproperty
   a_therm_shut: assert property (p_therm_shut) else $error("thermal shutdown indication wrong"); // R2

   property p_fan_double;
      @(posedge i_clock) disable iff (!i_resetn)
         (i_fan_a_fault && i_fan_b_fault) |=> (!o_main_output_enable && !o_fault_n_oe_n);
   endproperty
   a_fan_double: assert property (p_fan_double) else $error("double fan fault did not shut down"); // R4

   property p_overload_pulse;
      @(posedge i_clock) disable iff (!i_resetn)
         s_ovl_tick |=> (o_output_loss_warn_n_oe_n != $past(o_output_loss_warn_n_oe_n));
   endproperty
   a_overload_pulse: assert property (p_overload_pulse) else $error("power-good did not pulse"); // R6

   property p_input_limits;
      @(posedge i_clock) disable iff (!i_resetn)
         oor_only |=> (!o_led_output && !o_led_service && !o_led_fault && o_fault_n_oe_n && !o_output_loss_warn_n_oe_n);
   endproperty
   a_input_limits: assert property (p_input_limits) else $error("input limit indication wrong"); // R5

   property p_standby;
      @(posedge i_clock) disable iff (!i_resetn)
         sby_only |=> (!o_led_output && o_fault_n_oe_n && !o_output_loss_warn_n_oe_n && !o_module_inserted_out);
   endproperty
   a_standby: assert property (p_standby) else $error("standby indication wrong"); // R10

   property p_alert;
      @(posedge i_clock) disable iff (!i_resetn)
         (|rise) |-> ##[1:2] (o_alert_n_oe_n == 1'b0);
   endproperty
   a_alert: assert property (p_alert) else $error("alert not raised on new flag"); // R18

   property p_interlock;
      @(posedge i_clock) disable iff (!i_resetn)
         !i_interlock_mated |=> !o_main_output_enable;
   endproperty
   a_interlock: assert property (p_interlock) else $error("output enabled without interlock"); // R15

   property p_address;
      @(posedge i_clock) disable iff (!i_resetn)
         i_resetn ##1 i_resetn |-> (o_slot_address == $past(i_slot_address_level));
   endproperty
   a_address: assert property (p_address) else $error("slot address not followed"); // R16

endmodule

/* supply_cfg.svh */
// Offsets, field positions, reset values and timing constants of the alarm indicator block.
`ifndef SUPPLY_CFG_SVH
`define SUPPLY_CFG_SVH

// ==========================================================================
// Register byte addresses
`define REG_CTRL 8'h00
`define REG_FLAGS 8'h04
`define REG_EVENTS 8'h08
`define REG_LINES 8'h0c

// ==========================================================================
// Reset values
`define CTRL_BLINK_RESET 16'h00fa
`define MODE_RESET 1'b1

// ==========================================================================
// Condition flag positions
`define FLAG_COUNT 14
`define F_THERM_WARN 0
`define F_THERM_SHUT 1
`define F_FAN_A 2
`define F_FAN_B 3
`define F_INPUT_ABSENT 4
`define F_INPUT_LIMITS 5
`define F_FUSE 6
`define F_BOOST 7
`define F_OV_LATCH 8
`define F_OVERLOAD 9
`define F_INTERNAL 10
`define F_STANDBY 11
`define F_SERVICE_REQ 12
`define F_COMM_LOST 13

// ==========================================================================
// Timing
`define CLOCK_PERIOD_NS 8
`define PG_PULSE_TIME_NS 1000000
`define PG_PULSE_CYCLES (`PG_PULSE_TIME_NS / `CLOCK_PERIOD_NS)
`define PG_PULSE_WIDTH 17
`define BLINK_WIDTH 16

`endif

/* supply_pkg.sv */
// Types shared by the alarm indicator block.
package supply_pkg;

   typedef enum logic [0:0]
   {
      MODE_MULTIDROP = 1'b0,
      MODE_SERIAL = 1'b1
   } mgmt_mode_t;

endpackage

/* tick_divider.sv */
// Enabled cycle counter that emits one pulse every limit enabled cycles.
`timescale 1ns/1ns
module tick_divider
#(
   parameter int WIDTH = 16
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // Rate control
   input wire logic i_enable,
   input wire logic [WIDTH-1:0] i_limit,
   // Tick
   output logic o_tick
);

   generate
      if (WIDTH < 1)
      begin : g_bad_width
         $error("tick_divider width must be at least one");
      end
   endgenerate

   logic [WIDTH-1:0] count_r;
   logic [WIDTH-1:0] count_inc;
   logic wrap;

   // A limit of zero or one ticks on every enabled cycle.
   assign count_inc = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
   assign wrap = i_enable && (count_inc >= i_limit);
   assign o_tick = wrap;

   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
         count_r <= '0;
      else if (wrap)
         count_r <= '0;
      else if (i_enable)
         count_r <= count_inc;
   end

endmodule

/* shelf_monitor.sv */
// Shelf controller side: pulled-up alarm lines and the on/off request pin.
`timescale 1ns/1ns
module shelf_monitor
(
   // Alarm line drivers of the supply
   input wire logic [3:0] i_drive_n,
   input wire logic [3:0] i_drive_out,
   // Output run request from the shelf
   input wire logic i_request_on,
   // Line levels and the on/off pin
   output logic [3:0] o_level,
   output logic o_output_on_request_n
);
   // A released line floats up to the pull-up; it never keeps the last driven value.
   assign o_level = i_drive_n | i_drive_out;
   // Grounding the pin asks for the output; leaving it open keeps it off in serial mode only.
   assign o_output_on_request_n = !i_request_on;
endmodule

/* test_alarm_indicator.sv */
// Self-checking bench for the alarm indicator block.
`timescale 1ns/1ns
module test_alarm_indicator
   import supply_pkg::*;
;
   typedef struct {logic [13:0] f; logic [6:0] e;} row_t;
   logic clk = 0;
   logic rstn = 0;
   logic [7:0] adr = 0;
   logic [31:0] wd = 0;
   logic ws = 0;
   logic rs = 0;
   logic [13:0] fl = 0;
   logic req = 1;
   logic mated = 1;
   logic proto = 1;
   logic [3:0] slot = 0;
   logic [31:0] rdat;
   logic [31:0] rv;
   logic [3:0] oen;
   logic [3:0] dout;
   logic [3:0] lv;
   logic [3:0] sa;
   logic onr, li, lo, ls, lf, en, mi, ms;
   int failures = 0;
   int n_compared = 0;
   int c;
   wire [4:0] w = {li, lo, ls, lf, lv[2]};
   // Expected {in, out, service, fault LEDs, fault, overtemp, power-good lines}.
   row_t rows [15] = '{
      '{14'h0000, 7'h67},
      '{14'h0001, 7'h75},
      '{14'h0002, 7'h58},
      '{14'h0040, 7'h4a},
      '{14'h0080, 7'h4a},
      '{14'h0100, 7'h4a},
      '{14'h0004, 7'h6a},
      '{14'h0008, 7'h6a},
      '{14'h000c, 7'h4a},
      '{14'h0400, 7'h6b},
      '{14'h0800, 7'h46},
      '{14'h0010, 7'h06},
      '{14'h1001, 7'h75},
      '{14'h0202, 7'h58},
      '{14'h2000, 7'h67}};

   alarm_indicator #(.PULSE_CYCLES(8)) u_dut (.i_clock(clk), .i_resetn(rstn), .i_address(adr),
      .i_write_data(wd), .i_write_strobe(ws), .i_read_strobe(rs), .o_read_data(rdat),
      .i_therm_warn(fl[0]), .i_therm_shutdown(fl[1]), .i_fan_a_fault(fl[2]), .i_fan_b_fault(fl[3]),
      .i_input_absent(fl[4]), .i_input_out_of_limits(fl[5]), .i_fuse_blown(fl[6]), .i_boost_fail(fl[7]),
      .i_ov_latched(fl[8]), .i_overload(fl[9]), .i_internal_fault(fl[10]), .i_remote_standby(fl[11]),
      .i_service_request(fl[12]), .i_comm_lost(fl[13]), .i_output_on_request_n(onr),
      .i_interlock_mated(mated), .i_protocol_open(proto), .i_slot_address_level(slot),
      .i_shelf_address_level(4'h5), .i_fault_n_in(lv[0]), .o_fault_n_out(dout[0]),
      .o_fault_n_oe_n(oen[0]), .i_overtemp_warn_n_in(lv[1]), .o_overtemp_warn_n_out(dout[1]),
      .o_overtemp_warn_n_oe_n(oen[1]), .i_output_loss_warn_n_in(lv[2]), .o_output_loss_warn_n_out(dout[2]),
      .o_output_loss_warn_n_oe_n(oen[2]), .i_alert_n_in(lv[3]), .o_alert_n_out(dout[3]),
      .o_alert_n_oe_n(oen[3]), .o_led_input(li), .o_led_output(lo), .o_led_service(ls),
      .o_led_fault(lf), .o_module_inserted_out(mi), .o_main_output_enable(en), .o_slot_address(sa),
      .o_mode_serial(ms));

   shelf_monitor u_shelf (.i_drive_n(oen), .i_drive_out(dout), .i_request_on(req), .o_level(lv),
      .o_output_on_request_n(onr));

   initial
   begin
      forever #4 clk = ~clk;
   end

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task conclude();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      ws <= 1;
      adr <= a;
      wd <= d;
      @(posedge clk);
      ws <= 0;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rs <= 1;
      adr <= a;
      @(posedge clk);
      rs <= 0;
      #1 d = rdat;
   endtask

   task setf(input logic [13:0] f);
      @(posedge clk);
      fl <= f;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // Counts level changes over 64 cycles; blink and pulse rates come out of it.
   task blink(input logic [13:0] f, input int k, input int lo_c, input int hi_c);
      logic p;
      setf(f);
      c = 0;
      p = w[k];
      repeat (64)
      begin
         @(posedge clk);
         #1;
         if (w[k] !== p)
            c++;
         p = w[k];
      end
      chk("blink count", 32'(c >= lo_c && c <= hi_c), 1);
   endtask

   initial
   begin
      #200000;
      failures++;
      conclude();
   end

   initial
   begin
      repeat (2) @(posedge clk);
      #1;
      chk("reset lines", {oen, li, lo, ls, lf, en, ms}, 10'h2c1);
      @(posedge clk);
      rstn <= 1;
      rd(8'h00, rv);
      chk("ctrl reset", rv, 32'h00fa);
      wr(8'h10, 32'hffff);
      rd(8'h10, rv);
      chk("unmapped", rv, 0);
      wr(8'h00, 32'h2);
      rd(8'h00, rv);
      chk("ctrl", rv, 2);
      foreach (rows[i])
      begin
         setf(rows[i].f);
         chk("state", {li, lo, ls, lf, lv[0], lv[1], lv[2]}, rows[i].e);
         chk("enable", en, rows[i].e[5]);
         chk("present", mi, 0);
      end
      $display("state table done");
      blink(14'h0020, 4, 3, 5);
      chk("limits", {lo, lf, lv[0], lv[2]}, 4'h2);
      blink(14'h0200, 3, 3, 5);
      blink(14'h0200, 0, 7, 9);
      chk("overload", {lf, lv[0]}, 2'h1);
      blink(14'h1000, 2, 3, 5);
      @(posedge clk);
      proto <= 0;
      blink(14'h2000, 1, 3, 5);
      chk("comm lines", {lv[0], lv[1], lv[2], ms}, 4'he);
      wr(8'h00, 32'h1);
      blink(14'h2000, 1, 7, 9);
      $display("blink tests done");
      @(posedge clk);
      req <= 0;
      setf(0);
      chk("multidrop run", en, 1);
      @(posedge clk);
      proto <= 1;
      setf(0);
      chk("serial open pin", {en, ms}, 2'h1);
      @(posedge clk);
      req <= 1;
      mated <= 0;
      setf(0);
      chk("unmated", en, 0);
      @(posedge clk);
      mated <= 1;
      slot <= 4'ha;
      setf(0);
      chk("slot", sa, 4'ha);
      rd(8'h0c, rv);
      chk("lines reg", rv[12:8], 5'h15);
      $display("control pins done");
      wr(8'h08, 32'h3fff);
      repeat (2) @(posedge clk);
      #1 chk("alert idle", lv[3], 1);
      @(posedge clk);
      fl <= 14'h0400;
      c = 0;
      while (lv[3] !== 0 && c < 4)
      begin
         @(posedge clk);
         #1 c++;
      end
      chk("alert", lv[3], 0);
      if (lv[3] !== 0)
         conclude();
      rd(8'h08, rv);
      chk("events", rv, 32'h400);
      rd(8'h04, rv);
      chk("flags", rv, 32'h400);
      wr(8'h08, 32'h400);
      repeat (2) @(posedge clk);
      #1 chk("alert clear", lv[3], 1);
      $display("alert test done");
      @(posedge clk);
      rstn <= 0;
      repeat (3) @(posedge clk);
      #1 chk("reset again", {oen, li, lo, ls, lf, en, ms}, 10'h2c1);
      @(posedge clk);
      rstn <= 1;
      rd(8'h00, rv);
      chk("ctrl after reset", rv, 32'h00fa);
      $display("reset test done");
      conclude();
   end
endmodule
